// >>> logic/dcf_pkg.sv
// constants, types and register map of the clocked fifo storage core
// assumes a single 100 MHz clock and an axi4-lite register master
//
// Summary of operation
// - reset empties fifo, clears pointers, empty low
// - after reset outputs low if enabled
// - write enable low stores word, advances pointer
// - read enable low loads output, advances pointer
// - output enable low drives output register
// - only the read-holding device drives output
// - full fifo ignores writes entirely
// - empty fifo ignores reads, keeps last word
// - first word readable after empty rises
// - full release may slip one write edge
// - empty release may slip one read edge
// - synchronous almost flags may slip one edge
// - flags settle after retransmit recovery interval
// - dual-port array, flags from pointer distance
// - full flag low at depth, blocks writes
// - empty flag low at zero, blocks reads
// - almost flags compare offsets, default 127
// - retransmit returns read pointer to start
package dcf_pkg;

  localparam int          DCF_DATA_W     = 18;
  localparam int          DCF_DEPTH_DEF  = 8192;
  localparam int          DCF_OFF_W      = 14;
  localparam logic [13:0] DCF_EOFF_RST   = 14'h007f;
  localparam logic [13:0] DCF_FOFF_RST   = 14'h007f;

  // register byte offsets
  localparam logic [7:0]  DCF_REG_EOFF   = 8'h00;
  localparam logic [7:0]  DCF_REG_FOFF   = 8'h04;
  localparam logic [7:0]  DCF_REG_CTRL   = 8'h08;
  localparam logic [7:0]  DCF_REG_STAT   = 8'h0c;
  localparam logic [7:0]  DCF_REG_COUNT  = 8'h10;

  // control bit positions
  localparam int          DCF_CTRL_SRST  = 0;
  localparam int          DCF_CTRL_RT    = 1;

  // retransmit recovery, least time rounds up
  localparam int          DCF_CLK_NS     = 10;
  localparam int          DCF_RTR_NS     = 60;
  localparam int          DCF_RTR_CYC    = (DCF_RTR_NS + DCF_CLK_NS - 1) / DCF_CLK_NS;

  localparam logic [1:0]  DCF_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  DCF_RESP_SLV   = 2'h2;

  typedef enum logic [0:0] {
    DCF_W_IDLE = 1'b0,
    DCF_W_RESP = 1'b1
  } dcf_wstate_e;

  typedef struct packed {
    logic full_flag_n;
    logic almost_full_n;
    logic half_full_n;
    logic almost_empty_n;
    logic empty_flag_n;
  } dcf_flags_s;

endpackage

// >>> logic/dcf_ram.sv
// dual-port storage array of the fifo core
// assumes writes and reads on one clock; read port is combinational
`timescale 1ns/1ps
module dcf_ram #(
  parameter int DW = 18,
  parameter int AW = 13
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

// >>> logic/dcf_fifo_core.sv
// fifo storage core with flags, retransmit and axi4-lite registers
// assumes writer, reader and register master all run on aclk
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dcf_fifo_core
  import dcf_pkg::*;
#(
  parameter int DEPTH = DCF_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic      [1:0]            s_axi_bresp,
  // axi4-lite read
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [31:0]           s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  // fifo control
  input  wire logic                  fifo_reset_n,
  input  wire logic                  retransmit_pulse,
  input  wire logic                  sync_flag_select,
  // write side
  input  wire logic                  wr_en_n,
  input  wire logic [DCF_DATA_W-1:0] wr_data,
  // read side
  input  wire logic                  rd_en_n,
  input  wire logic                  out_enable_n,
  input  wire logic                  read_token,
  output logic      [DCF_DATA_W-1:0] rd_data,
  output logic                       rd_data_oe,
  // status flags
  output dcf_flags_s                 flags
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  if (DEPTH != 8192 && DEPTH != 16384) begin : g_bad_depth
    $error("dcf_fifo_core: DEPTH must be 8192 or 16384");
  end

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [PW-1:0]          wr_ptr_ff;
  logic [PW-1:0]          rd_ptr_ff;
  logic [PW-1:0]          wr_gray_ff;
  logic [PW-1:0]          rd_gray_ff;
  logic [DCF_DATA_W-1:0]  rd_data_ff;
  logic [DCF_OFF_W-1:0]   eoff_ff;
  logic [DCF_OFF_W-1:0]   foff_ff;
  logic                   srst_ff;
  logic                   rt_req_ff;
  logic [3:0]             rtr_cnt_ff;
  dcf_flags_s             flag_ff;

  ////////////////////////////////////////////////////////////////////////////
  // pointers and transfer decisions

  wire                    soft_clr = !fifo_reset_n || srst_ff;
  wire                    rtr_busy = (rtr_cnt_ff != 4'h0);
  wire                    rt_go    = (retransmit_pulse || rt_req_ff) && !soft_clr;
  wire                    wr_go    = !wr_en_n && flag_ff.full_flag_n && !soft_clr
                                     && !rtr_busy;
  wire                    rd_go    = !rd_en_n && flag_ff.empty_flag_n && !soft_clr
                                     && !rtr_busy && !rt_go;
  wire [PW-1:0]           wr_seen  = gray2bin(wr_gray_ff);
  wire [PW-1:0]           rd_seen  = gray2bin(rd_gray_ff);
  wire [DCF_DATA_W-1:0]   mem_q;

  logic [PW-1:0]          nxt_wr_ptr;
  logic [PW-1:0]          nxt_rd_ptr;

  // full ignores writes, empty ignores reads
  assign nxt_wr_ptr = soft_clr ? '0 : (wr_go ? wr_ptr_ff + PW'(1) : wr_ptr_ff);
  assign nxt_rd_ptr = soft_clr ? '0 :
                      rt_go    ? '0 :
                      rd_go    ? rd_ptr_ff + PW'(1) : rd_ptr_ff;

  dcf_ram #(
    .DW (DCF_DATA_W),
    .AW (AW)
  ) u_ram (
    .clk     (aclk),
    .wr_en   (wr_go),
    .wr_addr (wr_ptr_ff[AW-1:0]),
    .wr_data (wr_data),
    .rd_addr (rd_ptr_ff[AW-1:0]),
    .rd_data (mem_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      wr_gray_ff <= '0;
      rd_gray_ff <= '0;
    end else begin
      wr_ptr_ff  <= nxt_wr_ptr;
      rd_ptr_ff  <= nxt_rd_ptr;
      // gray copies lag a cycle so flags release late, never early
      wr_gray_ff <= soft_clr ? '0 : bin2gray(wr_ptr_ff);
      rd_gray_ff <= soft_clr ? '0 : bin2gray(rd_ptr_ff);
    end
  end

  // output register holds the last word while nothing is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_ff <= '0;
    end else if (soft_clr) begin
      rd_data_ff <= '0;
    end else if (rd_go) begin
      rd_data_ff <= mem_q;
    end
  end

  assign rd_data    = rd_data_ff;
  assign rd_data_oe = !out_enable_n && read_token;

  ////////////////////////////////////////////////////////////////////////////
  // flags

  wire [PW-1:0]           cnt_r   = wr_seen - nxt_rd_ptr;
  wire [PW-1:0]           cnt_w   = nxt_wr_ptr - rd_seen;
  wire [PW-1:0]           free_w  = PW'(DEPTH) - cnt_w;
  wire [PW-1:0]           cnt_t   = wr_ptr_ff - rd_ptr_ff;
  wire [PW-1:0]           eoff_w  = PW'(eoff_ff);
  wire [PW-1:0]           foff_w  = PW'(foff_ff);
  wire                    ae_live = (cnt_t > eoff_w);
  wire                    af_live = ((PW'(DEPTH) - cnt_t) > foff_w);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= '{full_flag_n: 1'b1, almost_full_n: 1'b1, half_full_n: 1'b1,
                   almost_empty_n: 1'b0, empty_flag_n: 1'b0};
    end else if (soft_clr) begin
      flag_ff <= '{full_flag_n: 1'b1, almost_full_n: 1'b1, half_full_n: 1'b1,
                   almost_empty_n: 1'b0, empty_flag_n: 1'b0};
    end else begin
      flag_ff.empty_flag_n   <= (cnt_r != '0);
      flag_ff.full_flag_n    <= (cnt_w != PW'(DEPTH));
      flag_ff.almost_empty_n <= (cnt_r > eoff_w);
      flag_ff.almost_full_n  <= (free_w > foff_w);
      flag_ff.half_full_n    <= (cnt_w <= PW'(DEPTH / 2));
    end
  end

  // sync_flag_select high gives the unclocked almost flags
  always_comb begin
    flags                = flag_ff;
    flags.almost_empty_n = sync_flag_select ? ae_live : flag_ff.almost_empty_n;
    flags.almost_full_n  = sync_flag_select ? af_live : flag_ff.almost_full_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // retransmit recovery: accesses wait until pointers and flags settle

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtr_cnt_ff <= 4'h0;
    end else if (soft_clr) begin
      rtr_cnt_ff <= 4'h0;
    end else if (rt_go) begin
      rtr_cnt_ff <= 4'(DCF_RTR_CYC);
    end else if (rtr_busy) begin
      rtr_cnt_ff <= rtr_cnt_ff - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read outstanding

  dcf_wstate_e            wstate_ff;
  logic                   aw_hold_ff;
  logic                   w_hold_ff;
  logic [7:0]             awaddr_ff;
  logic [31:0]            wdata_ff;
  logic [3:0]             wstrb_ff;
  logic [1:0]             bresp_ff;
  logic                   rvalid_ff;
  logic [31:0]            rdata_ff;
  logic [1:0]             rresp_ff;

  wire                    aw_take  = s_axi_awvalid && s_axi_awready;
  wire                    w_take   = s_axi_wvalid && s_axi_wready;
  wire                    ar_take  = s_axi_arvalid && s_axi_arready;
  wire                    wr_fire  = aw_hold_ff && w_hold_ff && (wstate_ff == DCF_W_IDLE);
  wire                    hit_eoff = (awaddr_ff == DCF_REG_EOFF);
  wire                    hit_foff = (awaddr_ff == DCF_REG_FOFF);
  wire                    hit_ctrl = (awaddr_ff == DCF_REG_CTRL);
  wire                    wr_map   = hit_eoff || hit_foff || hit_ctrl;
  wire [7:0]              ar_off   = s_axi_araddr[7:0];
  wire [DCF_OFF_W-1:0]    eoff_in  = {wstrb_ff[1] ? wdata_ff[13:8] : eoff_ff[13:8],
                                      wstrb_ff[0] ? wdata_ff[7:0]  : eoff_ff[7:0]};
  wire [DCF_OFF_W-1:0]    foff_in  = {wstrb_ff[1] ? wdata_ff[13:8] : foff_ff[13:8],
                                      wstrb_ff[0] ? wdata_ff[7:0]  : foff_ff[7:0]};
  wire                    ctrl_wr  = wr_fire && hit_ctrl && wstrb_ff[0];

  assign s_axi_awready = !aw_hold_ff && (wstate_ff == DCF_W_IDLE);
  assign s_axi_wready  = !w_hold_ff && (wstate_ff == DCF_W_IDLE);
  assign s_axi_bvalid  = (wstate_ff == DCF_W_RESP);
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_hold_ff <= wr_fire ? 1'b0 : (aw_hold_ff || aw_take);
      w_hold_ff  <= wr_fire ? 1'b0 : (w_hold_ff || w_take);
      awaddr_ff  <= aw_take ? {s_axi_awaddr[7:2], 2'b00} : awaddr_ff;
      wdata_ff   <= w_take ? s_axi_wdata : wdata_ff;
      wstrb_ff   <= w_take ? s_axi_wstrb : wstrb_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_ff <= DCF_W_IDLE;
      bresp_ff  <= DCF_RESP_OKAY;
    end else begin
      case (wstate_ff)
        DCF_W_IDLE: begin
          if (wr_fire) begin
            wstate_ff <= DCF_W_RESP;
            bresp_ff  <= wr_map ? DCF_RESP_OKAY : DCF_RESP_SLV;
          end
        end
        DCF_W_RESP: begin
          if (s_axi_bready) begin
            wstate_ff <= DCF_W_IDLE;
          end
        end
        default: begin
          wstate_ff <= DCF_W_IDLE;
        end
      endcase
    end
  end

  // offsets and one-shot control requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eoff_ff   <= DCF_EOFF_RST;
      foff_ff   <= DCF_FOFF_RST;
      srst_ff   <= 1'b0;
      rt_req_ff <= 1'b0;
    end else begin
      eoff_ff   <= (wr_fire && hit_eoff) ? eoff_in : eoff_ff;
      foff_ff   <= (wr_fire && hit_foff) ? foff_in : foff_ff;
      srst_ff   <= ctrl_wr && wdata_ff[DCF_CTRL_SRST];
      rt_req_ff <= ctrl_wr && wdata_ff[DCF_CTRL_RT];
    end
  end

  logic [31:0]            rd_mux;
  logic                   rd_map;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    case (ar_off)
      DCF_REG_EOFF:  rd_mux = 32'(eoff_ff);
      DCF_REG_FOFF:  rd_mux = 32'(foff_ff);
      DCF_REG_CTRL:  rd_mux = 32'h0000_0000;
      DCF_REG_STAT:  rd_mux = {26'h0, rtr_busy, flags};
      DCF_REG_COUNT: rd_mux = 32'(cnt_t);
      default:       rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= DCF_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_map ? DCF_RESP_OKAY : DCF_RESP_SLV;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_empty_out: assert property (disable iff (1'b0)
    !aresetn |=> !flags.empty_flag_n && rd_data == '0 && rd_ptr_ff == '0)
    else $error("reset did not leave fifo empty with zero output");

  a_write_advance: assert property (
    wr_go |=> wr_ptr_ff == $past(wr_ptr_ff) + PW'(1))
    else $error("accepted write did not advance write pointer");

  a_read_loads: assert property (
    rd_go |=> rd_data == $past(mem_q))
    else $error("accepted read did not load output register");

  a_full_blocks: assert property (
    !flags.full_flag_n && !soft_clr |=> $stable(wr_ptr_ff))
    else $error("write pointer moved while full");

  a_empty_holds: assert property (
    !flags.empty_flag_n && !soft_clr |=> $stable(rd_data))
    else $error("output changed while empty");

  a_drive_token: assert property (
    !read_token |-> !rd_data_oe)
    else $error("output driven without read token");

  a_empty_release: assert property (
    wr_go && !flags.empty_flag_n ##1 !soft_clr ##1 (!soft_clr && !flags.empty_flag_n)
    |=> flags.empty_flag_n)
    else $error("empty flag not released two edges after write");

  a_full_release: assert property (
    rd_go && !flags.full_flag_n ##1 !soft_clr ##1 (!soft_clr && !flags.full_flag_n)
    |=> flags.full_flag_n)
    else $error("full flag not released two edges after read");

  a_sync_almost: assert property (
    !sync_flag_select && !flags.empty_flag_n |-> !flags.almost_empty_n)
    else $error("synchronous almost empty high while empty");

  a_retransmit_rec: assert property (
    rt_go |=> rd_ptr_ff == '0 ##0 rtr_busy [*6] ##1 !rtr_busy)
    else $error("retransmit pointer or recovery interval wrong");

endmodule

// >>> dv/dcf_host_model.sv
// host writer and reader beside the fifo core
// assumes one clock; each task starts on the next rising edge
`timescale 1ns/1ps
module dcf_host_model
  import dcf_pkg::*;
(
  // clock and resets
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  fifo_reset_n,
  // write side
  output logic                       wr_en_n,
  output logic      [DCF_DATA_W-1:0] wr_data,
  // read side
  output logic                       rd_en_n
);
  initial begin
    wr_en_n = 1'b1;
    rd_en_n = 1'b1;
    wr_data = 18'h15555;
  end
  ////////////////////////////////////////
  // no access while either reset is held
  task automatic hold_off;
    do @(posedge aclk); while (!(aresetn && fifo_reset_n));
  endtask
  // ascending run of words, gap idle cycles between them for a slow writer
  task automatic push(input logic [DCF_DATA_W-1:0] d, input int n, input int gap);
    hold_off;
    for (int i = 0; i < n; i++) begin
      wr_en_n <= 1'b0;
      wr_data <= d + DCF_DATA_W'(i);
      @(posedge aclk);
      if (gap > 0) begin
        wr_en_n <= 1'b1;
        repeat (gap) @(posedge aclk);
      end
    end
    wr_en_n <= 1'b1;
    // released bus shows the inverse, so a stale word never passes
    wr_data <= ~wr_data;
  endtask
  task automatic pop(input int n);
    hold_off;
    rd_en_n <= 1'b0;
    repeat (n) @(posedge aclk);
    rd_en_n <= 1'b1;
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench of the fifo storage core
// assumes the host model drives the write and read sides
`timescale 1ns/1ps
module tb_top import dcf_pkg::*;;
  localparam int D = 8192;
  logic        aclk, aresetn;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        fifo_reset_n, retransmit_pulse, sync_flag_select;
  logic        wr_en_n, rd_en_n, out_enable_n, read_token, rd_data_oe;
  logic [17:0] wr_data, rd_data;
  dcf_flags_s  flags;
  wire  [17:0] q = rd_data_oe ? rd_data : 'z;
  int          fails, check_count;

  dcf_fifo_core #(.DEPTH(D)) i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .fifo_reset_n,
    .retransmit_pulse, .sync_flag_select, .wr_en_n, .wr_data, .rd_en_n, .out_enable_n,
    .read_token, .rd_data, .rd_data_oe, .flags);
  dcf_host_model i_host (.aclk, .aresetn, .fifo_reset_n, .wr_en_n, .wr_data, .rd_en_n);

  always #5 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic tally(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      fails++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic chk_flag(input logic g, e, input string m); tally(g === e, m); endtask
  task automatic chk_word(input logic [17:0] g, e, input string m); tally(g === e, m); endtask
  task automatic chk_reg(input logic [31:0] g, e, input string m); tally(g === e, m); endtask
  task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    // start on a rising edge so back-to-back calls never reassign a strobe
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    settle(0);
    chk_flag(flags.empty_flag_n, 1'b0, "reset empty");
    chk_flag(flags.full_flag_n, 1'b1, "reset not full");
    chk_word(q, 18'h0, "reset output low");
    @(posedge aclk);
    out_enable_n <= 1'b1;
    settle(0);
    chk_word(q, 'z, "disabled output floats");
    @(posedge aclk);
    out_enable_n <= 1'b0;
    read_token   <= 1'b0;
    settle(0);
    chk_word(q, 'z, "no token no drive");
    @(posedge aclk);
    read_token <= 1'b1;
    $display("test reset done");
  endtask
  task automatic t_reg;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(32'(DCF_REG_EOFF), d, r);
    chk_reg(d, 32'h7f, "empty offset reset");
    axi_rd(32'(DCF_REG_FOFF), d, r);
    chk_reg(d, 32'h7f, "full offset reset");
    axi_wr(32'(DCF_REG_EOFF), 32'h3, r);
    axi_rd(32'(DCF_REG_EOFF), d, r);
    chk_reg(d, 32'h3, "empty offset write");
    axi_wr(32'h40, 32'h1, r);
    chk_reg(32'(r), 32'(DCF_RESP_SLV), "unmapped write");
    axi_rd(32'h40, d, r);
    chk_reg(32'(r), 32'(DCF_RESP_SLV), "unmapped read");
    $display("test registers done");
  endtask
  task automatic t_order;
    i_host.push(18'h100, 1, 0);
    settle(0);
    chk_flag(flags.empty_flag_n, 1'b0, "empty before copy");
    settle(2);
    chk_flag(flags.empty_flag_n, 1'b1, "empty released");
    i_host.push(18'h101, 2, 1);
    settle(3);
    chk_flag(flags.almost_empty_n, 1'b0, "almost empty at offset");
    @(posedge aclk);
    sync_flag_select <= 1'b1;
    i_host.push(18'h103, 1, 0);
    settle(0);
    chk_flag(flags.almost_empty_n, 1'b1, "live almost empty");
    settle(3);
    chk_flag(flags.almost_empty_n, 1'b1, "above offset");
    @(posedge aclk);
    sync_flag_select <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      i_host.pop(1);
      settle(0);
      chk_word(q, 18'h100 + 18'(i), "read order");
    end
    chk_flag(flags.empty_flag_n, 1'b0, "empty after last read");
    i_host.pop(2);
    settle(0);
    chk_word(q, 18'h103, "last word kept");
    $display("test order done");
  endtask
  task automatic t_full;
    logic [31:0] d;
    logic [1:0]  r;
    i_host.push(18'h1000, D - 128, 0);
    settle(3);
    chk_flag(flags.almost_full_n, 1'b1, "free above offset");
    chk_flag(flags.half_full_n, 1'b0, "over half full");
    i_host.push(18'h1000 + 18'(D - 128), 1, 0);
    settle(3);
    chk_flag(flags.almost_full_n, 1'b0, "free at offset");
    chk_flag(flags.full_flag_n, 1'b1, "not yet full");
    i_host.push(18'h1000 + 18'(D - 127), 127, 0);
    settle(0);
    chk_flag(flags.full_flag_n, 1'b0, "full at depth");
    i_host.push(18'h2aaaa, 1, 0);
    axi_rd(32'(DCF_REG_COUNT), d, r);
    chk_reg(d, 32'(D), "count held at depth");
    i_host.pop(1);
    settle(0);
    chk_word(q, 18'h1000, "oldest word intact");
    @(posedge aclk);
    fifo_reset_n <= 1'b0;
    @(posedge aclk);
    fifo_reset_n <= 1'b1;
    settle(0);
    chk_flag(flags.empty_flag_n, 1'b0, "clear empties");
    chk_word(q, 18'h0, "clear output low");
    axi_rd(32'(DCF_REG_COUNT), d, r);
    chk_reg(d, 32'h0, "clear count");
    $display("test full done");
  endtask
  task automatic t_retx;
    logic [31:0] d;
    logic [1:0]  r;
    i_host.push(18'h50, 4, 0);
    settle(3);
    i_host.pop(2);
    retransmit_pulse <= 1'b1;
    @(posedge aclk);
    retransmit_pulse <= 1'b0;
    settle(DCF_RTR_CYC + 1);
    chk_flag(flags.empty_flag_n, 1'b1, "flags after recovery");
    i_host.pop(1);
    settle(0);
    chk_word(q, 18'h50, "replay from start");
    axi_wr(32'(DCF_REG_CTRL), 32'h1, r);
    settle(0);
    chk_flag(flags.empty_flag_n, 1'b0, "soft clear empties");
    chk_word(q, 18'h0, "soft clear output low");
    axi_rd(32'(DCF_REG_STAT), d, r);
    chk_reg(d, 32'h1c, "status after soft clear");
    $display("test retransmit done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    fails = 0;
    check_count = 0;
    aclk = 0;
    aresetn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    fifo_reset_n = 1'b1;
    retransmit_pulse = 1'b0;
    // registered almost flags unless a test switches to live ones
    sync_flag_select = 1'b0;
    out_enable_n = 1'b0;
    read_token = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_reg;
    t_order;
    t_full;
    t_retx;
    final_report;
  end
  initial begin
    #200000;
    fails++;
    $display("FAIL %0t watchdog expired", $time);
    final_report;
  end
endmodule
